// ===== design/pidc_controller.sv
// PID process controller: source selection, PID terms, limits, filter and output stage.
`timescale 1ns/1ps
`default_nettype none
module pidc_controller #(
  parameter int TICK_CYCLES = pidc_pkg::TICK_CYC
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rstn,
  // Digital input terminals and their function codes
  input  wire logic [4:0]        diPin,
  input  wire logic [5:0]        diFunc [pidc_pkg::NUM_DI],
  // Drive state
  input  wire logic              runActive,
  input  wire logic              resetCmd,
  // Reference, analog and pulse values, 0.01 percent of maximum frequency
  input  wire logic [15:0]       freqRef,
  input  wire logic [15:0]       analogIn2,
  input  wire logic [15:0]       pulseFreq,
  // Source selectors
  input  wire logic [4:0]        aiFunc,
  input  wire logic [1:0]        pulseFunc,
  // Tuning parameters
  input  wire logic [2:0]        pidModeSelect,
  input  wire logic [15:0]       proportionalGain,
  input  wire logic [15:0]       integralTime,
  input  wire logic [15:0]       integralLimit,
  input  wire logic [15:0]       derivativeTime,
  input  wire logic [15:0]       pidOutputLimit,
  input  wire logic signed [15:0] pidOffsetAdjust,
  input  wire logic [15:0]       filterTimeConst,
  input  wire logic              outputPolaritySelect,
  input  wire logic [15:0]       pidOutputGain,
  input  wire logic              negOutReverseSelect,
  input  wire logic              reverseProhibit,
  input  wire logic [15:0]       targetRampTime,
  // Serial register port
  input  wire logic              regWrite,
  input  wire logic [15:0]       regAddr,
  input  wire logic [15:0]       regWdata,
  output logic [15:0]            regRdata,
  // Drive output
  output logic [15:0]            outFreq,
  output logic                   reverseDir
);
  import pidc_pkg::*;

  pidc_div_if div ();
  pidc_state_t state_r;
  logic [4:0]  diMeta_r;
  logic [4:0]  diSync_r;
  logic [15:0] tickCnt_r;
  logic        tick;
  logic [15:0] serTarget_r;
  logic [15:0] srcSel_r;
  logic        divWait_r;
  pidc_wide_t  rampQ8_r, pTerm_r, dTerm_r, prevD_r, integ_r, filtIn_r, filtQ8_r;
  pidc_wide_t  tgtSel, fbSel, tgtQ8, err, dSrc, pNow, dNow, divNum, divDen, quoS, divDelta;
  pidc_wide_t  iLimQ, oLimQ, offQ, sumLim, yOut, corr, fin;
  logic        pidOff, clrInteg, holdInteg, bypassRamp, needDiv;

  // True when any terminal set to the given code is on.
  function automatic logic diOn(input logic [5:0] code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_DI; i++) begin
      if (diFunc[i] == code && diSync_r[i]) hit = 1'b1;
    end
    return hit;
  endfunction

  // ****************************************************************
  // Terminal synchroniser and loop tick
  // ****************************************************************
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      diMeta_r <= 5'h0;
      diSync_r <= 5'h0;
    end else begin
      diMeta_r <= diPin;
      diSync_r <= diMeta_r;
    end
  end

  // The loop samples once per tick; the whole pipeline fits well inside one.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) tickCnt_r <= 16'h0;
    else if (tick) tickCnt_r <= 16'h0;
    else tickCnt_r <= tickCnt_r + 16'h1;
  end
  assign tick = (tickCnt_r == 16'(TICK_CYCLES - 1));

  // ****************************************************************
  // Serial registers
  // ****************************************************************
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      serTarget_r <= 16'h0;
      srcSel_r    <= 16'h0;
      regRdata    <= 16'h0;
    end else begin
      if (regWrite && regAddr == REG_TARGET) serTarget_r <= regWdata;
      if (regWrite && regAddr == REG_SRCSEL) srcSel_r <= regWdata;
      if (regAddr == REG_TARGET) regRdata <= serTarget_r;
      else if (regAddr == REG_SRCSEL) regRdata <= srcSel_r;
      else regRdata <= 16'h0;
    end
  end

  // ****************************************************************
  // Source selection and control decodes
  // ****************************************************************
  always_comb begin
    if (srcSel_r[SRC_TARGET_BIT]) tgtSel = pidc_wide_t'(serTarget_r);
    else if (aiFunc == AI_TARGET) tgtSel = pidc_wide_t'(analogIn2);
    else if (pulseFunc == PULSE_TARGET) tgtSel = pidc_wide_t'(pulseFreq);
    else tgtSel = pidc_wide_t'(freqRef);
    if (aiFunc == AI_FEEDBACK) fbSel = pidc_wide_t'(analogIn2);
    else if (pulseFunc == PULSE_FEEDBACK) fbSel = pidc_wide_t'(pulseFreq);
    else fbSel = '0;
  end

  assign pidOff     = (pidModeSelect == MODE_OFF) || (pidModeSelect > MODE_ADD_FB) || diOn(DI_PID_OFF);
  assign clrInteg   = diOn(DI_INT_CLR) || resetCmd || (!runActive && !pidOff);
  assign holdInteg  = diOn(DI_INT_HOLD);
  assign bypassRamp = (diOn(DI_SOFT_START) && runActive) || targetRampTime == 16'h0;
  assign tgtQ8      = tgtSel <<< Q8_FRAC;
  // Ramped target, with the optional error sign swap.
  assign err        = diOn(DI_ERR_INVERT) ? fbSel - (rampQ8_r >>> Q8_FRAC)
                                          : (rampQ8_r >>> Q8_FRAC) - fbSel;
  assign dSrc       = (pidModeSelect == MODE_DIR_ERR || pidModeSelect == MODE_ADD_ERR) ? err : -fbSel;
  assign pNow       = pidc_clamp(pidc_mul_q8(err, proportionalGain), WIDE_LIM);
  assign dNow       = pidc_clamp(pidc_mul_q8(pidc_clamp((dSrc - prevD_r) * $signed({32'h0, derivativeTime})
                      * TICKS_PER_HUND, WIDE_LIM), proportionalGain), WIDE_LIM);
  assign iLimQ      = ($signed({32'h0, integralLimit}) * PCT_TENTH) <<< INT_FRAC;
  assign oLimQ      = $signed({32'h0, pidOutputLimit}) * PCT_TENTH;
  assign offQ       = pidc_wide_t'(pidOffsetAdjust) * PCT_TENTH;
  assign sumLim     = pidc_clamp(pTerm_r + (integ_r >>> INT_FRAC) + dTerm_r, oLimQ);
  assign divDelta   = (filtIn_r <<< Q8_FRAC) - filtQ8_r;

  // ****************************************************************
  // Divider requests
  // ****************************************************************
  always_comb begin
    divNum  = '0;
    divDen  = '0;
    needDiv = 1'b0;
    unique case (state_r)
      S_RAMP: begin
        divNum  = pidc_wide_t'(RAMP_NUM);
        divDen  = $signed({32'h0, targetRampTime}) * TICKS_PER_TENTH;
        needDiv = !bypassRamp;
      end
      S_INTEG: begin
        divNum  = (pTerm_r < 0 ? -pTerm_r : pTerm_r) <<< INT_FRAC;
        divDen  = $signed({32'h0, integralTime}) * TICKS_PER_TENTH;
        needDiv = !clrInteg && !holdInteg && integralTime != 16'h0;
      end
      S_FILT: begin
        divNum  = divDelta < 0 ? -divDelta : divDelta;
        divDen  = $signed({32'h0, filterTimeConst}) * TICKS_PER_HUND;
        needDiv = filterTimeConst != 16'h0;
      end
      S_IDLE, S_CALC, S_SUM, S_OUT: begin
        needDiv = 1'b0;
      end
    endcase
  end
  assign div.start    = needDiv && !divWait_r;
  assign div.dividend = divNum[31:0];
  assign div.divisor  = divDen[31:0];
  assign quoS         = pidc_wide_t'(div.quotient);

  pidc_divider u_div (
    .mclk (mclk),
    .rstn (rstn),
    .div  (div.server)
  );

  // A stage waiting on the divider moves on only with the answer.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) divWait_r <= 1'b0;
    else if (div.done) divWait_r <= 1'b0;
    else if (div.start) divWait_r <= 1'b1;
  end

  // ****************************************************************
  // Loop sequencer
  // ****************************************************************
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) state_r <= S_IDLE;
    else begin
      unique case (state_r)
        S_IDLE:  if (tick) state_r <= S_RAMP;
        S_RAMP:  if (!needDiv || div.done) state_r <= S_CALC;
        S_CALC:  state_r <= S_INTEG;
        S_INTEG: if (!needDiv || div.done) state_r <= S_SUM;
        S_SUM:   state_r <= S_FILT;
        S_FILT:  if (!needDiv || div.done) state_r <= S_OUT;
        S_OUT:   state_r <= S_IDLE;
      endcase
    end
  end

  // Target ramp; the step never overshoots the selected target.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) rampQ8_r <= '0;
    else if (state_r == S_RAMP && bypassRamp) rampQ8_r <= tgtQ8;
    else if (state_r == S_RAMP && div.done) begin
      if (tgtQ8 > rampQ8_r) rampQ8_r <= (tgtQ8 - rampQ8_r > quoS) ? rampQ8_r + quoS : tgtQ8;
      else rampQ8_r <= (rampQ8_r - tgtQ8 > quoS) ? rampQ8_r - quoS : tgtQ8;
    end
  end

  // Proportional and derivative terms are taken once per tick.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pTerm_r <= '0;
      dTerm_r <= '0;
      prevD_r <= '0;
    end else if (state_r == S_CALC) begin
      pTerm_r <= pNow;
      dTerm_r <= (derivativeTime == 16'h0) ? '0 : dNow;
      prevD_r <= dSrc;
    end
  end

  // Integral accumulator with clear, hold and limit.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) integ_r <= '0;
    else if (clrInteg) integ_r <= '0;
    else if (state_r == S_INTEG && div.done && !holdInteg)
      integ_r <= pidc_clamp(integ_r + (pTerm_r < 0 ? -quoS : quoS), iLimQ);
  end

  // Limited sum plus offset, then the first-order filter state.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      filtIn_r <= '0;
      filtQ8_r <= '0;
    end else begin
      if (state_r == S_SUM) filtIn_r <= sumLim + offQ;
      if (state_r == S_FILT && filterTimeConst == 16'h0) filtQ8_r <= filtIn_r <<< Q8_FRAC;
      else if (state_r == S_FILT && div.done) filtQ8_r <= filtQ8_r + (divDelta < 0 ? -quoS : quoS);
    end
  end

  // ****************************************************************
  // Output stage
  // ****************************************************************
  assign yOut = outputPolaritySelect ? -(filtQ8_r >>> Q8_FRAC) : (filtQ8_r >>> Q8_FRAC);
  assign corr = pidc_clamp(pidc_mul_q8(yOut, pidOutputGain), OUT_MAX);
  assign fin  = (pidModeSelect <= MODE_DIR_FB) ? corr : pidc_wide_t'(freqRef) + corr;

  // Negative results reverse only when allowed and not prohibited.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      outFreq    <= 16'h0;
      reverseDir <= 1'b0;
    end else if (state_r == S_OUT) begin
      if (pidOff) begin
        outFreq    <= freqRef;
        reverseDir <= 1'b0;
      end else if (fin >= 0) begin
        outFreq    <= 16'(pidc_clamp(fin, OUT_MAX));
        reverseDir <= 1'b0;
      end else if (negOutReverseSelect && !reverseProhibit) begin
        outFreq    <= 16'(pidc_clamp(-fin, OUT_MAX));
        reverseDir <= 1'b1;
      end else begin
        outFreq    <= 16'h0;
        reverseDir <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_writeTarget;
    regWrite && regAddr == REG_TARGET && srcSel_r[SRC_TARGET_BIT];
  endsequence
  a_bypass_ref: assert property (@(posedge mclk) disable iff (!rstn)
    (state_r == S_OUT && pidOff) |=> (outFreq == $past(freqRef) && !reverseDir))
    else $error("bypass did not pass the reference");
  a_integ_clear: assert property (@(posedge mclk) disable iff (!rstn)
    clrInteg |=> integ_r == 0) else $error("integral not cleared");
  a_integ_hold: assert property (@(posedge mclk) disable iff (!rstn)
    (holdInteg && !clrInteg) |=> $stable(integ_r)) else $error("integral moved while held");
  a_soft_start: assert property (@(posedge mclk) disable iff (!rstn)
    (state_r == S_RAMP && bypassRamp) |=> rampQ8_r == $past(tgtQ8)) else $error("ramp not skipped");
  a_serial_target: assert property (@(posedge mclk) disable iff (!rstn)
    s_writeTarget |=> tgtSel == pidc_wide_t'($past(regWdata))) else $error("serial target not used");
  a_integ_limit: assert property (@(posedge mclk) disable iff (!rstn)
    (state_r == S_INTEG && div.done) |=> (integ_r <= $past(iLimQ) && integ_r >= -$past(iLimQ)))
    else $error("integral beyond limit");
  a_out_limit: assert property (@(posedge mclk) disable iff (!rstn)
    (state_r == S_SUM) |=> (filtIn_r - $past(offQ) <= $past(oLimQ) && filtIn_r - $past(offQ) >= -$past(oLimQ)))
    else $error("PID result beyond output limit");
  a_no_reverse: assert property (@(posedge mclk) disable iff (!rstn)
    (state_r == S_OUT && reverseProhibit) |=> !reverseDir) else $error("reverse while prohibited");
  a_deriv_off: assert property (@(posedge mclk) disable iff (!rstn)
    (state_r == S_CALC && derivativeTime == 16'h0) |=> dTerm_r == 0) else $error("derivative not off");
endmodule
`default_nettype wire

// ===== design/pidc_pkg.sv
// Package of constants, types and functions for the PID process controller.
`default_nettype none
package pidc_pkg;
  // ****************************************************************
  // Serial registers and selector codes
  // ****************************************************************
  localparam logic [15:0] REG_TARGET     = 16'h0006;
  localparam logic [15:0] REG_SRCSEL     = 16'h000f;
  localparam int          SRC_TARGET_BIT = 1;
  localparam logic [5:0]  DI_PID_OFF     = 6'h13;
  localparam logic [5:0]  DI_INT_CLR     = 6'h1e;
  localparam logic [5:0]  DI_INT_HOLD    = 6'h1f;
  localparam logic [5:0]  DI_SOFT_START  = 6'h22;
  localparam logic [5:0]  DI_ERR_INVERT  = 6'h23;
  localparam logic [4:0]  AI_FEEDBACK    = 5'h0b;
  localparam logic [4:0]  AI_TARGET      = 5'h0c;
  localparam logic [1:0]  PULSE_FEEDBACK = 2'h1;
  localparam logic [1:0]  PULSE_TARGET   = 2'h2;
  localparam logic [2:0]  MODE_OFF       = 3'h0;
  localparam logic [2:0]  MODE_DIR_ERR   = 3'h1;
  localparam logic [2:0]  MODE_DIR_FB    = 3'h2;
  localparam logic [2:0]  MODE_ADD_ERR   = 3'h3;
  localparam logic [2:0]  MODE_ADD_FB    = 3'h4;
  localparam int          NUM_DI         = 5;

  // ****************************************************************
  // Timing and scaling
  // ****************************************************************
  localparam int CLK_HZ          = 50_000_000;
  localparam int TICK_US         = 1000;
  localparam int TICK_CYC        = CLK_HZ / 1_000_000 * TICK_US;
  localparam int TICKS_PER_TENTH = 100_000 / TICK_US;
  localparam int TICKS_PER_HUND  = 10_000 / TICK_US;
  localparam int FULL_SCALE      = 10000;
  localparam int PCT_TENTH       = 10;
  localparam int GAIN_SHIFT      = 8;
  localparam int INT_FRAC        = 16;
  localparam int Q8_FRAC         = 8;
  localparam int WIDE_LIM        = 2 * FULL_SCALE;
  localparam int OUT_MAX         = 32767;
  localparam int RAMP_NUM        = FULL_SCALE * 256;
  localparam logic [5:0] DIV_STEPS = 6'h20;

  typedef logic signed [47:0] pidc_wide_t;
  typedef enum {S_IDLE, S_RAMP, S_CALC, S_INTEG, S_SUM, S_FILT, S_OUT} pidc_state_t;

  // Symmetric saturation to plus or minus lim.
  function automatic pidc_wide_t pidc_clamp(input pidc_wide_t x, input pidc_wide_t lim);
    pidc_wide_t r;
    r = x;
    if (x > lim) r = lim;
    if (x < -lim) r = -lim;
    return r;
  endfunction

  // Multiply by an unsigned gain with eight fraction bits.
  function automatic pidc_wide_t pidc_mul_q8(input pidc_wide_t a, input logic [15:0] g);
    pidc_wide_t p;
    p = a * $signed({32'h0, g});
    return p >>> GAIN_SHIFT;
  endfunction
endpackage
`default_nettype wire

// ===== design/pidc_div_if.sv
// Interface carrying one divide request and its answer.
`timescale 1ns/1ps
`default_nettype none
interface pidc_div_if;
  logic        start;
  logic        busy;
  logic        done;
  logic [31:0] dividend;
  logic [31:0] divisor;
  logic [31:0] quotient;
  modport client (output start, output dividend, output divisor, input busy, input done, input quotient);
  modport server (input start, input dividend, input divisor, output busy, output done, output quotient);
endinterface
`default_nettype wire

// ===== design/pidc_divider.sv
// Serial restoring divider shared by the ramp, integral and filter stages.
`timescale 1ns/1ps
`default_nettype none
module pidc_divider (
  // Clock and reset
  input wire logic     mclk,
  input wire logic     rstn,
  // Divide request and answer
  pidc_div_if.server   div
);
  logic [32:0] rem_r;
  logic [31:0] quo_r;
  logic [5:0]  cnt_r;
  logic        busy_r;
  logic        done_r;
  logic [32:0] trial;

  // One quotient bit per cycle keeps area small; the loop runs far slower than this.
  assign trial = {rem_r[31:0], quo_r[31]} - {1'b0, div.divisor};

  // ****************************************************************
  // Shift and subtract sequencer
  // ****************************************************************
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rem_r  <= 33'h0;
      quo_r  <= 32'h0;
      cnt_r  <= 6'h0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else if (!busy_r) begin
      done_r <= 1'b0;
      if (div.start) begin
        rem_r  <= 33'h0;
        quo_r  <= div.dividend;
        cnt_r  <= pidc_pkg::DIV_STEPS;
        busy_r <= 1'b1;
      end
    end else begin
      if (trial[32]) begin
        rem_r <= {rem_r[31:0], quo_r[31]};
        quo_r <= {quo_r[30:0], 1'b0};
      end else begin
        rem_r <= trial;
        quo_r <= {quo_r[30:0], 1'b1};
      end
      cnt_r <= cnt_r - 6'h01;
      if (cnt_r == 6'h01) begin
        busy_r <= 1'b0;
        done_r <= 1'b1;
      end
    end
  end

  // Answer signals.
  assign div.busy     = busy_r;
  assign div.done     = done_r;
  assign div.quotient = quo_r;

  // The answer arrives exactly 33 edges after the request is taken.
  sequence s_divTaken;
    div.start && !busy_r;
  endsequence
  sequence s_divAnswer;
    (!div.done)[*8] ##25 div.done;
  endsequence
  a_div_latency: assert property (@(posedge mclk) disable iff (!rstn) s_divTaken |=> s_divAnswer)
    else $error("divider answer latency wrong");
endmodule
`default_nettype wire

// ===== test/pidc_sensor_model.sv
// Behavioural process sensor that reports the process level as PID feedback.
`timescale 1ns/1ps
`default_nettype none
module pidc_sensor_model (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // Process level and response speed
  input  wire logic [15:0] level,
  input  wire logic        slow,
  // Measured feedback
  output logic [15:0]      fbVal
);
  // A slow sensor creeps one count per cycle, so the loop must live with a lagging feedback.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) fbVal <= 16'h0;
    else if (!slow) fbVal <= level;
    else if (fbVal < level) fbVal <= fbVal + 16'h1;
    else if (fbVal > level) fbVal <= fbVal - 16'h1;
  end
endmodule
`default_nettype wire

// ===== test/tb_top.sv
// Self-checking testbench of the PID process controller with a sensor model.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ****************************************
  // Stimulus, observation and bookkeeping
  // ****************************************
  localparam int TK = 200;
  logic        mclk = 1'b0, rstn = 1'b0, runActive = 1'b0, resetCmd = 1'b0, regWrite = 1'b0, sw = 1'b0, slow = 1'b0;
  logic        outputPolaritySelect = 1'b0, negOutReverseSelect = 1'b0, reverseProhibit = 1'b0, reverseDir;
  logic [4:0]  diPin = 5'h0, aiFunc = 5'h0;
  logic [5:0]  diFunc [5] = '{6'h13, 6'h1e, 6'h1f, 6'h22, 6'h23};
  logic [1:0]  pulseFunc = 2'h0;
  logic [2:0]  pidModeSelect = 3'h0;
  logic [15:0] freqRef = 16'h0, tgtV = 16'h0, lvl = 16'h0, regAddr = 16'h0, regWdata = 16'h0, regRdata, outFreq, fb;
  logic [15:0] proportionalGain = 16'h100, integralTime = 16'h0, integralLimit = 16'h0, derivativeTime = 16'h0;
  logic [15:0] pidOutputLimit = 16'h3e8, filterTimeConst = 16'h0, pidOutputGain = 16'h100, targetRampTime = 16'h0;
  logic signed [15:0] pidOffsetAdjust = 16'sh0;
  logic [31:0] seed = 32'h122b;
  int          n_mismatch = 0, n_checks = 0;
  wire  [15:0] analogIn2 = sw ? tgtV : fb;
  wire  [15:0] pulseFreq = sw ? fb : tgtV;

  // Free-running 50 MHz clock.
  always #10 mclk = ~mclk;

  pidc_controller #(.TICK_CYCLES(TK)) dut (.mclk, .rstn, .diPin, .diFunc, .runActive, .resetCmd, .freqRef, .analogIn2,
    .pulseFreq, .aiFunc, .pulseFunc, .pidModeSelect, .proportionalGain, .integralTime, .integralLimit,
    .derivativeTime, .pidOutputLimit, .pidOffsetAdjust, .filterTimeConst, .outputPolaritySelect, .pidOutputGain,
    .negOutReverseSelect, .reverseProhibit, .targetRampTime, .regWrite, .regAddr, .regWdata, .regRdata, .outFreq,
    .reverseDir);
  pidc_sensor_model sensor (.mclk, .rstn, .level(lvl), .slow, .fbVal(fb));

  // Next value of the stimulus shift register.
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Expected direction and magnitude for error e and integral i, derivative and filter off.
  function automatic logic [16:0] expOut(input int e, input int i);
    int s;
    int l;
    l = int'(pidOutputLimit) * 10;
    s = (e * int'(proportionalGain)) >>> 8;
    s = s > 20000 ? 20000 : s < -20000 ? -20000 : s;
    s = s + i;
    s = s > l ? l : s < -l ? -l : s;
    s = s + int'(pidOffsetAdjust) * 10;
    if (outputPolaritySelect) s = -s;
    s = (s * int'(pidOutputGain)) >>> 8;
    s = s > 32767 ? 32767 : s < -32767 ? -32767 : s;
    if (pidModeSelect > 3'h2) s = s + int'(freqRef);
    s = s > 32767 ? 32767 : s;
    if (s >= 0) return {1'b0, 16'(s)};
    if (negOutReverseSelect && !reverseProhibit) return {1'b1, 16'(-s)};
    return 17'h0;
  endfunction

  // Compare and count; a mismatch is reported at once.
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle register write strobe.
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge mclk);
    regWrite <= 1'b0;
  endtask

  // Register read; the registered answer is steady one edge after the address.
  task automatic rd(input logic [15:0] a, output logic [16:0] d);
    @(posedge mclk);
    regAddr <= a;
    repeat (2) @(posedge mclk);
    d = {1'b0, regRdata};
  endtask

  // Let n full loop periods pass so that a whole pass sees the new inputs.
  task automatic settle(input int n);
    repeat (n * TK + 60) @(posedge mclk);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin : main
    logic [16:0] rv;
    int t;
    int f;
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    runActive <= 1'b1;
    // The source word starts at zero, the target word keeps a write, and an unmapped place reads zero.
    rd(16'h000f, rv);
    chk(rv, 17'h0);
    wr(16'h0006, 16'h0bb8);
    wr(16'h0010, 16'h5a5a);
    rd(16'h0006, rv);
    chk(rv, 17'h0bb8);
    rd(16'h0010, rv);
    chk(rv, 17'h0);
    // Random passes cycling through the four target sources and modes 2, 3 and 4 (the seed never yields mode 1).
    for (int k = 0; k < 16; k++) begin
      seed = lfsr(seed);
      t = int'(seed[27:16]);
      f = int'(seed[31:21]);
      pidModeSelect <= 3'(seed[1:0]) + 3'h1;
      outputPolaritySelect <= seed[2];
      negOutReverseSelect <= seed[3];
      reverseProhibit <= seed[4];
      pidOutputGain <= seed[5] ? 16'h180 : 16'h100;
      pidOutputLimit <= seed[6] ? 16'h64 : 16'h3e8;
      pidOffsetAdjust <= 16'(int'(seed[11:8]) - 8);
      freqRef <= (k % 4 == 3) ? 16'(t) : {4'h0, seed[13:2]};
      sw <= (k % 4 == 1);
      aiFunc <= (k % 4 == 1) ? 5'h0c : 5'h0b;
      pulseFunc <= (k % 4 == 1) ? 2'h1 : (k % 4 == 2) ? 2'h2 : 2'h0;
      tgtV <= 16'(t);
      lvl <= 16'(f);
      wr(16'h000f, (k % 4 == 0) ? 16'h2 : 16'h0);
      wr(16'h0006, 16'(t));
      settle(2);
      chk({reverseDir, outFreq}, expOut(t - f, 0));
    end
    // Corner cases: pulse target 3000, analog feedback 1000, plain output stage.
    pidModeSelect <= 3'h1;
    outputPolaritySelect <= 1'b0;
    pidOutputGain <= 16'h100;
    pidOutputLimit <= 16'h3e8;
    pidOffsetAdjust <= 16'sh0;
    negOutReverseSelect <= 1'b1;
    reverseProhibit <= 1'b0;
    sw <= 1'b0;
    aiFunc <= 5'h0b;
    pulseFunc <= 2'h2;
    tgtV <= 16'd3000;
    lvl <= 16'd1000;
    diPin <= 5'h10;
    settle(2);
    chk({reverseDir, outFreq}, expOut(-2000, 0));
    diPin <= 5'h01;
    settle(2);
    chk({reverseDir, outFreq}, {1'b0, freqRef});
    diPin <= 5'h00;
    pidModeSelect <= 3'h0;
    settle(2);
    chk({reverseDir, outFreq}, {1'b0, freqRef});
    // A long target ramp holds the output back until the soft-start terminal bypasses it.
    pidModeSelect <= 3'h1;
    tgtV <= 16'd0;
    lvl <= 16'd0;
    settle(2);
    targetRampTime <= 16'd255;
    tgtV <= 16'd3000;
    settle(2);
    chk({16'h0, outFreq < 16'd2990}, 17'h1);
    diPin <= 5'h08;
    settle(2);
    chk({reverseDir, outFreq}, expOut(3000, 0));
    diPin <= 5'h00;
    targetRampTime <= 16'h0;
    // Integral grows to its limit behind a lagging sensor, then is cleared and frozen.
    slow <= 1'b1;
    lvl <= 16'd1000;
    integralTime <= 16'h1;
    integralLimit <= 16'h32;
    settle(40);
    chk({reverseDir, outFreq}, expOut(2000, 500));
    for (int c = 0; c < 2; c++) begin
      diPin <= c ? 5'h04 : 5'h06;
      resetCmd <= c[0];
      settle(2);
      diPin <= 5'h04;
      resetCmd <= 1'b0;
      settle(3);
      chk({reverseDir, outFreq}, expOut(2000, 0));
      diPin <= 5'h00;
      settle(40);
    end
    end_of_test();
  end
endmodule
`default_nettype wire
